//--- logic/eep_pkg.sv
/*
 * eep_pkg: constants and carrier types for the serial eeprom slave engine.
 * assumes a 20 MHz system clock sampling the two-wire bus pins.
 */
package eep_pkg;
	// fixed memory type code of the select byte; the value is arbitrary
	localparam logic [3:0] EEP_TYPE_CODE = 4'h6;
	// bit positions inside the select byte
	localparam int EEP_SEL_RW_POS = 0;
	localparam int EEP_SEL_CS_LSB = 1;
	localparam int EEP_SEL_TYPE_LSB = 4;
	// bit slot of the acknowledge (ninth pulse) and bit count at which a stop may start programming
	localparam logic [3:0] EEP_ACK_SLOT = 4'h8;
	localparam logic [3:0] EEP_STOP_SLOT = 4'h1;
	// mask of the implemented address range, wraps from last to 00h
	localparam logic [15:0] EEP_ADDR_MASK = 16'h7FFF;
	// reset values
	localparam logic [15:0] EEP_ADDR_RST = 16'h0000;
	localparam logic [7:0] EEP_BYTE_RST = 8'h00;
	localparam logic [3:0] EEP_CNT_RST = 4'h0;
	// self-timed programming time, in ns, and its count at 20 MHz
	localparam int EEP_CLK_NS = 50;
	localparam int EEP_PROG_TIME_NS = 5000000;
	localparam int EEP_PROG_CYCLES = EEP_PROG_TIME_NS / EEP_CLK_NS;
	localparam logic [23:0] EEP_TMR_RST = 24'h000000;

	typedef enum logic [3:0] {
		EEP_IDLE = 4'b0000,
		EEP_DEVSEL = 4'b0001,
		EEP_ADDR_HI = 4'b0010,
		EEP_ADDR_LO = 4'b0011,
		EEP_WDATA = 4'b0100,
		EEP_RDATA = 4'b0101,
		EEP_BUSY = 4'b0110
	} eep_state_t;

	// request to the memory array and its page latches
	typedef struct packed {
		logic wr;
		logic commit;
		logic abort;
		logic [15:0] addr;
		logic [7:0] data;
	} eep_mem_t;
endpackage

//--- logic/eep_slave.sv
/*
 * eep_slave: two-wire eeprom slave protocol engine with page latch port.
 * assumes scl/sda/strap pins are asynchronous to i_mclk and that the
 * array answers i_mem_rdata combinationally from o_mem.addr.
 */
// Notes on behaviour
// - start is sda falling while scl high; master starts every command.
// - watch for start always except while programming; ignore bus until start.
// - stop is sda rising while scl high; it ends the exchange.
// - read ended by master nack then stop puts device in standby.
// - transmitter releases sda after eight bits; receiver pulls low on ninth.
// - sda sampled on scl rise; master changes sda only while scl low.
// - select byte msb first; type code and chip select bits must match.
// - eighth select bit is direction, one read, zero write.
// - on match acknowledge ninth slot; on mismatch release and go standby.
// - after write select, take two address bytes, acknowledging each.
// - sixteen bit address, upper byte first then lower byte.
// - write protect high from start to address end refuses data bytes.
// - programming starts only on stop right after a data byte acknowledge.
// - during programming sda stays released and all requests are ignored.
// - byte write is one data byte, acked only when unprotected, then stop.
// - page write takes one to sixty-four bytes within a single row.
// - after each written byte only the low six address bits advance.
// - polling select byte gets no acknowledge until programming is done.
// - reads behave the same whatever the write protect level.
// - random read is address write, repeated start, read select, nack, stop.
// - with write protect high select and address bytes are still acked.
// - address counter advances by one after every byte output in a read.
// - read address wraps from the last location back to 00h.
// - nack after a sent byte ends the read and enters standby.
module eep_slave
	import eep_pkg::*;
#(
	parameter int PROG_CYCLES = EEP_PROG_CYCLES
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// two-wire bus pins
	input wire logic i_scl,
	input wire logic i_sda_i,
	output logic o_sda_o,
	output logic o_sda_oe,
	// straps
	input wire logic i_write_protect_in,
	input wire logic i_chip_sel_bit0,
	input wire logic i_chip_sel_bit1,
	input wire logic i_chip_sel_bit2,
	// memory array port
	output eep_mem_t o_mem,
	input wire logic [7:0] i_mem_rdata,
	output logic o_busy
);
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic scl_d_r;
	logic sda_d_r;
	eep_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic in_ack_r, in_ack_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic wp_seen_r, wp_seen_nxt;
	logic wr_any_r, wr_any_nxt;
	logic oe_r, oe_nxt;
	logic [23:0] tmr_r, tmr_nxt;
	eep_mem_t mem_r, mem_nxt;
	logic [23:0] busy_len_r;

	wire scl_s = sync2_r[0];
	wire sda_s = sync2_r[1];
	wire wp_s = sync2_r[2];
	wire [2:0] cs_s = sync2_r[5:3];
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
	wire busy = state_r == EEP_BUSY;
	wire rx_state = state_r == EEP_DEVSEL || state_r == EEP_ADDR_HI ||
		state_r == EEP_ADDR_LO || state_r == EEP_WDATA;
	wire sel_match = sh_r[7:EEP_SEL_TYPE_LSB] == EEP_TYPE_CODE &&
		sh_r[EEP_SEL_TYPE_LSB-1:EEP_SEL_CS_LSB] == cs_s;
	wire enter_ack = scl_fall & (cnt_r == EEP_ACK_SLOT) & ~in_ack_r;
	wire leave_ack = scl_fall & in_ack_r;
	wire wr_ok = state_r == EEP_WDATA && !wp_seen_r;
	wire go_wr = enter_ack & wr_ok;
	wire commit_ok = state_r == EEP_WDATA && cnt_r == EEP_STOP_SLOT &&
		!in_ack_r && wr_any_r;
	wire prog_done = tmr_r == PROG_CYCLES[23:0] - 24'h000001;

	function automatic logic [15:0] eep_inc(input logic [15:0] a);
		eep_inc = (a + 16'h0001) & EEP_ADDR_MASK;
	endfunction

	// two-flop synchronisers for every pin, one more stage for edges
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sync1_r <= 6'h03;
			sync2_r <= 6'h03;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			sync1_r <= {i_chip_sel_bit2, i_chip_sel_bit1, i_chip_sel_bit0,
				i_write_protect_in, i_sda_i, i_scl};
			sync2_r <= sync1_r;
			scl_d_r <= sync2_r[0];
			sda_d_r <= sync2_r[1];
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		in_ack_nxt = in_ack_r;
		sh_nxt = sh_r;
		addr_nxt = addr_r;
		wp_seen_nxt = wp_seen_r;
		wr_any_nxt = wr_any_r;
		oe_nxt = oe_r;
		tmr_nxt = EEP_TMR_RST;
		mem_nxt = '0;
		if (busy)
		begin
			// bus is ignored while the timer runs
			oe_nxt = 1'b0;
			tmr_nxt = tmr_r + 24'h000001;
			if (prog_done)
				state_nxt = EEP_IDLE;
		end
		else if (start_det)
		begin
			state_nxt = EEP_DEVSEL;
			cnt_nxt = EEP_CNT_RST;
			in_ack_nxt = 1'b0;
			oe_nxt = 1'b0;
			wp_seen_nxt = wp_s;
			wr_any_nxt = 1'b0;
			mem_nxt.abort = wr_any_r;
		end
		else if (stop_det)
		begin
			state_nxt = commit_ok ? EEP_BUSY : EEP_IDLE;
			mem_nxt.commit = commit_ok;
			mem_nxt.abort = wr_any_r & ~commit_ok;
			wr_any_nxt = 1'b0;
			oe_nxt = 1'b0;
		end
		else if (state_r != EEP_IDLE)
		begin
			if (state_r == EEP_DEVSEL || state_r == EEP_ADDR_HI ||
				state_r == EEP_ADDR_LO)
				wp_seen_nxt = wp_seen_r | wp_s;
			if (scl_rise && !in_ack_r && cnt_r != EEP_ACK_SLOT)
			begin
				// shift in on the rise; read mode shifts data out
				sh_nxt = {sh_r[6:0], sda_s};
				cnt_nxt = cnt_r + 4'h1;
			end
			else if (scl_rise && in_ack_r && state_r == EEP_RDATA)
			begin
				addr_nxt = eep_inc(addr_r);
				if (sda_s)
					state_nxt = EEP_IDLE;
			end
			if (scl_fall && !in_ack_r && cnt_r != EEP_ACK_SLOT &&
				state_r == EEP_RDATA)
				oe_nxt = ~sh_r[7];
			else if (enter_ack)
			begin
				in_ack_nxt = 1'b1;
				oe_nxt = 1'b0;
				if (state_r == EEP_DEVSEL)
				begin
					oe_nxt = sel_match;
					if (!sel_match)
						state_nxt = EEP_IDLE;
				end
				else if (rx_state)
					oe_nxt = state_r != EEP_WDATA || wr_ok;
				if (state_r == EEP_ADDR_HI)
					addr_nxt[15:8] = sh_r;
				if (state_r == EEP_ADDR_LO)
					addr_nxt[7:0] = sh_r;
				if (go_wr)
				begin
					mem_nxt.wr = 1'b1;
					mem_nxt.data = sh_r;
					wr_any_nxt = 1'b1;
					addr_nxt[5:0] = addr_r[5:0] + 6'h01;
				end
			end
			else if (leave_ack)
			begin
				in_ack_nxt = 1'b0;
				cnt_nxt = EEP_CNT_RST;
				oe_nxt = 1'b0;
				case (state_r)
					EEP_DEVSEL:
						state_nxt = sh_r[EEP_SEL_RW_POS] ? EEP_RDATA :
							EEP_ADDR_HI;
					EEP_ADDR_HI:
						state_nxt = EEP_ADDR_LO;
					EEP_ADDR_LO:
						state_nxt = EEP_WDATA;
					default:
						state_nxt = state_r;
				endcase
				if (state_r == EEP_RDATA || (state_r == EEP_DEVSEL &&
					sh_r[EEP_SEL_RW_POS]))
				begin
					// read path never looks at write protect
					sh_nxt = i_mem_rdata;
					oe_nxt = ~i_mem_rdata[7];
				end
			end
		end
		mem_nxt.addr = go_wr ? addr_r : addr_nxt;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_r <= EEP_IDLE;
			cnt_r <= EEP_CNT_RST;
			in_ack_r <= 1'b0;
			sh_r <= EEP_BYTE_RST;
			addr_r <= EEP_ADDR_RST;
			wp_seen_r <= 1'b0;
			wr_any_r <= 1'b0;
			oe_r <= 1'b0;
			tmr_r <= EEP_TMR_RST;
			mem_r <= '0;
			o_busy <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			in_ack_r <= in_ack_nxt;
			sh_r <= sh_nxt;
			addr_r <= addr_nxt;
			wp_seen_r <= wp_seen_nxt;
			wr_any_r <= wr_any_nxt;
			oe_r <= oe_nxt;
			tmr_r <= tmr_nxt;
			mem_r <= mem_nxt;
			o_busy <= state_nxt == EEP_BUSY;
		end
	end

	assign o_sda_o = 1'b0;
	assign o_sda_oe = oe_r;
	assign o_mem = mem_r;

	chk_busy_release: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		busy |=> !o_sda_oe)
		else $error("sda driven during programming");
	chk_busy_ignores_start: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		busy && !prog_done && start_det |=> state_r == EEP_BUSY)
		else $error("start accepted during programming");
	chk_start_to_select: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		!busy && start_det |=> state_r == EEP_DEVSEL && !o_sda_oe)
		else $error("start not taken");
	chk_stop_ends_exchange: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		!busy && stop_det |=> (state_r == EEP_IDLE || state_r == EEP_BUSY)
			&& !o_sda_oe)
		else $error("stop did not end exchange");
	chk_commit_slot: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_mem.commit |-> $past(state_r) == EEP_WDATA &&
			$past(cnt_r) == EEP_STOP_SLOT && state_r == EEP_BUSY)
		else $error("programming started outside stop slot");
	chk_protect_blocks: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		state_r == EEP_WDATA && wp_seen_r && enter_ack |=>
			!o_mem.wr && !o_sda_oe)
		else $error("protected data byte accepted");
	chk_row_wrap: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_mem.wr |-> addr_r[15:6] == o_mem.addr[15:6] &&
			addr_r[5:0] == o_mem.addr[5:0] + 6'h01)
		else $error("write address left its row");
	chk_nack_standby: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		state_r == EEP_RDATA && in_ack_r && scl_rise && sda_s && !stop_det
			|=> state_r == EEP_IDLE ##1 !o_sda_oe)
		else $error("read continued after nack");
	chk_select_mismatch: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		state_r == EEP_DEVSEL && enter_ack && !sel_match && !start_det &&
			!stop_det |=> state_r == EEP_IDLE && !o_sda_oe)
		else $error("mismatched select byte answered");
	// length of the current programming cycle, for the check below
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			busy_len_r <= EEP_TMR_RST;
		else if (o_busy)
			busy_len_r <= busy_len_r + 24'h000001;
		else
			busy_len_r <= EEP_TMR_RST;
	end

	chk_prog_length: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		$fell(o_busy) |-> busy_len_r == PROG_CYCLES[23:0])
		else $error("programming cycle length wrong");
endmodule

//--- test/eep_host_model.sv
/*
 * eep_host_model: two-wire bus master that drives scl and its share of sda.
 * assumes the bench forms the wired-and sda level with a pull-up and feeds
 * it back on i_sda; one bit slot is 8 clocks (4 low, 4 high).
 */
module eep_host_model
(
	// clock
	input wire logic i_mclk,
	// bus
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// data moves only mid-low; the wire is read at the end of the high half
	task automatic slot(input logic b, output logic seen);
		o_scl <= 1'b0;
		tick(2);
		o_sda <= b;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		seen = i_sda;
	endtask
	task automatic start();
		o_scl <= 1'b0;
		tick(2);
		o_sda <= 1'b1;
		tick(2);
		o_scl <= 1'b1;
		tick(2);
		o_sda <= 1'b0;
		tick(2);
	endtask
	// scl is left high afterwards: the link clock stands still between frames
	task automatic stop();
		o_scl <= 1'b0;
		tick(2);
		o_sda <= 1'b0;
		tick(2);
		o_scl <= 1'b1;
		tick(2);
		o_sda <= 1'b1;
		tick(2);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			slot(d[i], s);
		slot(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			slot(1'b1, d[i]);
		slot(~ack, s);
	endtask
endmodule

//--- test/eep_slave_bench.sv
/*
 * eep_slave_bench: self-checking bench for the eeprom slave engine.
 * assumes the host model above, straps 101 and an array that answers
 * the low address byte xor 5A.
 */
module eep_slave_bench;
	import eep_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROG = 200;
	localparam logic [7:0] SEL_WR = {EEP_TYPE_CODE, 3'h5, 1'b0};
	localparam logic [7:0] SEL_RD = {EEP_TYPE_CODE, 3'h5, 1'b1};
	localparam logic [7:0] SEL_ALT = {EEP_TYPE_CODE, 3'h4, 1'b0};
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic wp = 1'b0;
	logic [2:0] cs = 3'h5;
	int abort_n = 0;
	logic scl;
	logic m_sda;
	logic oe;
	logic sda_o;
	logic busy;
	eep_mem_t mem;
	eep_mem_t wr_seen;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int wr_n = 0;
	int commit_n = 0;
	int busy_n = 0;
	wire logic sda = m_sda & ~(oe & ~sda_o);
	always #25 i_mclk = ~i_mclk;
	eep_host_model eep_host_model_i (.i_mclk(i_mclk), .i_sda(sda),
		.o_scl(scl), .o_sda(m_sda));
	eep_slave #(.PROG_CYCLES(PROG)) eep_slave_i (.i_mclk(i_mclk),
		.i_rst_b(i_rst_b), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o),
		.o_sda_oe(oe), .i_write_protect_in(wp), .i_chip_sel_bit0(cs[0]),
		.i_chip_sel_bit1(cs[1]), .i_chip_sel_bit2(cs[2]), .o_mem(mem),
		.i_mem_rdata(mem.addr[7:0] ^ 8'h5A), .o_busy(busy));
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		busy_n <= busy_n + int'(busy === 1'b1);
		commit_n <= commit_n + int'(mem.commit === 1'b1);
		abort_n <= abort_n + int'(mem.abort === 1'b1);
		if (mem.wr === 1'b1)
		begin
			wr_seen <= mem;
			wr_n <= wr_n + 1;
		end
		if (cyc == 30000)
		begin
			errors = errors + 1;
			tally_and_finish();
		end
	end
	task automatic check(input string w, input logic [23:0] exp,
		input logic [23:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", w, exp, seen);
		end
	endtask
	// select, two address bytes; returns the three acknowledges anded
	task automatic header(input logic [15:0] ad, output logic ok);
		logic a;
		logic b;
		logic c;
		eep_host_model_i.start();
		eep_host_model_i.send_byte(SEL_WR, a);
		eep_host_model_i.send_byte(ad[15:8], b);
		eep_host_model_i.send_byte(ad[7:0], c);
		ok = a & b & c;
	endtask
	task automatic t_page_write();
		logic a;
		header(16'h00BF, a);
		check("header ack", 24'h1, 24'(a));
		eep_host_model_i.send_byte(8'hC3, a);
		check("data ack", 24'h1, 24'(a));
		check("first wr", 24'h00BFC3, {wr_seen.addr, wr_seen.data});
		eep_host_model_i.send_byte(8'h5A, a);
		check("wrap wr", 24'h00805A, {wr_seen.addr, wr_seen.data});
		eep_host_model_i.stop();
		repeat (6) @(posedge i_mclk);
		check("commit", 24'h1, 24'(commit_n));
		eep_host_model_i.start();
		eep_host_model_i.send_byte(SEL_WR, a);
		check("busy poll", 24'h0, 24'(a));
		for (int n = 0; n < 400 && busy === 1'b1; n++)
			@(posedge i_mclk);
		check("prog time", 24'(PROG), 24'(busy_n));
		eep_host_model_i.start();
		eep_host_model_i.send_byte(SEL_WR, a);
		check("ready poll", 24'h1, 24'(a));
		eep_host_model_i.stop();
		repeat (6) @(posedge i_mclk);
		check("no commit", 24'h1, 24'(commit_n));
		$display("page write done");
	endtask
	task automatic t_protected();
		logic a;
		wp <= 1'b1;
		header(16'h0200, a);
		check("wp header", 24'h1, 24'(a));
		eep_host_model_i.send_byte(8'h77, a);
		check("wp data", 24'h0, 24'(a));
		eep_host_model_i.stop();
		repeat (6) @(posedge i_mclk);
		check("wp wr", 24'h2, 24'(wr_n));
		check("wp busy", 24'h0, 24'(busy));
		wp <= 1'b0;
		$display("protected write done");
	endtask
	task automatic t_mismatch();
		logic a;
		eep_host_model_i.start();
		eep_host_model_i.send_byte(SEL_ALT, a);
		check("wrong select", 24'h0, 24'(a));
		eep_host_model_i.send_byte(SEL_WR, a);
		check("no start", 24'h0, 24'(a));
		eep_host_model_i.stop();
		cs <= 3'h4;
		eep_host_model_i.start();
		eep_host_model_i.send_byte(SEL_ALT, a);
		check("pin select", 24'h1, 24'(a));
		eep_host_model_i.stop();
		cs <= 3'h5;
		$display("mismatch done");
	endtask
	task automatic t_random_read();
		logic a;
		logic [7:0] d;
		wp <= 1'b1;
		header(16'h7FFF, a);
		eep_host_model_i.start();
		eep_host_model_i.send_byte(SEL_RD, a);
		check("read sel", 24'h1, 24'(a));
		eep_host_model_i.recv_byte(1'b1, d);
		check("read last", 24'hA5, 24'(d));
		eep_host_model_i.recv_byte(1'b0, d);
		check("read wrap", 24'h5A, 24'(d));
		eep_host_model_i.stop();
		repeat (6) @(posedge i_mclk);
		check("read idle", 24'h0, 24'(oe));
		check("read commit", 24'h1, 24'(commit_n));
		wp <= 1'b0;
		$display("random read done");
	endtask
	task automatic t_abort();
		logic a;
		header(16'h0105, a);
		check("abort header", 24'h1, 24'(a));
		eep_host_model_i.send_byte(8'h11, a);
		check("abort data", 24'h1, 24'(a));
		eep_host_model_i.start();
		eep_host_model_i.stop();
		repeat (6) @(posedge i_mclk);
		check("abort", 24'h1, 24'(abort_n));
		check("abort commit", 24'h1, 24'(commit_n));
		check("abort busy", 24'h0, 24'(busy));
		$display("aborted write done");
	endtask
	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_mclk);
		t_page_write();
		t_protected();
		t_mismatch();
		t_random_read();
		t_abort();
		tally_and_finish();
	end
endmodule
